// ### hw/arb_timer.sv
/*
 * Serial bus arbiter and bit timer with APB register access.
 * Assumes receive_line and oscillator_clock are asynchronous pins and
 * serial_tx_internal comes from the transmitter on pclk.
 */
`timescale 1ns/100ps
module arb_timer #(
    parameter logic [7:0] BUS_DIV = arb_timer_pkg::BUS_DIV_DEF,
    parameter logic [7:0] PRE_DIV = arb_timer_pkg::PRE_DIV_DEF
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire arb_timer_pkg::apb_req_type apb_req,
    output      arb_timer_pkg::apb_rsp_type apb_rsp,
    input  wire logic                       receive_line,
    input  wire logic                       oscillator_clock,
    input  wire logic                       serial_tx_internal,
    output      logic                       transmit_pin,
    output      logic                       irq
);
    import arb_timer_pkg::*;

    state_type s_r;
    state_type s_nxt;
    logic      rx_fall;
    logic      rx_rise;
    logic      tx_rise;
    logic      tx_fall;
    logic      bus_tick;
    logic      src_tick;
    logic      pre_tick;
    logic      cnt_tick;
    logic      setup;
    logic      wr;
    logic      wr_ctrl;
    logic      lost_ev;
    logic      done_ev;
    logic      ovfl_ev;
    logic [8:0] samp;

    // Decode an offset into a register index; 7 means unmapped.
    function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CTRL:  decode = 3'h0;
            OFS_COUNT: decode = 3'h1;
            OFS_IRQST: decode = 3'h2;
            OFS_IRQMK: decode = 3'h3;
            OFS_CFG:   decode = 3'h4;
            default:   decode = 3'h7;
        endcase
    endfunction

    // Read mux over the current state.
    function automatic logic [31:0] rd_mux(input state_type s,
                                           input logic [2:0] idx);
        rd_mux = 32'h0000_0000;
        case (idx)
            3'h0: begin
                rd_mux[CTRL_MODE_HI] = s.mode[1];
                rd_mux[CTRL_MODE_LO] = s.mode[0];
                rd_mux[CTRL_LOST]    = s.lost;
                rd_mux[CTRL_CLK_SEL] = s.clk_sel;
                rd_mux[CTRL_DONE]    = s.done;
                rd_mux[CTRL_RUNNING] = s.running;
                rd_mux[CTRL_OVFL]    = s.ovfl;
                rd_mux[CTRL_MSB]     = s.count[8];
            end
            3'h1: rd_mux[7:0] = s.count[7:0];
            3'h2: rd_mux[2:0] = s.irq_st;
            3'h3: rd_mux[2:0] = s.irq_mask;
            3'h4: rd_mux[CFG_BAUD_SRC] = s.baud_src;
            default: rd_mux = 32'h0000_0000;
        endcase
    endfunction

    // Receive edge detection reads only the second synchroniser stage onward.
    assign rx_fall = s_r.rx_prev & ~s_r.rx_sync;
    assign rx_rise = ~s_r.rx_prev & s_r.rx_sync;
    assign tx_rise = ~s_r.tx_prev & serial_tx_internal;
    assign tx_fall = s_r.tx_prev & ~serial_tx_internal;

    // Bus clock divider tick, and the prescaler fed from either source.
    assign bus_tick = (s_r.bus_div == BUS_DIV - 8'h01);
    assign src_tick = s_r.baud_src ? (s_r.osc_sync & ~s_r.osc_prev)
                                   : 1'b1;
    assign pre_tick = src_tick & (s_r.pre_div == PRE_DIV - 8'h01);
    // Half of the prescaler output, or the bus clock divided.
    assign cnt_tick = s_r.clk_sel ? (pre_tick & s_r.half)
                                  : bus_tick;

    // The compare is made one tick early, so the sample lands on the very
    // tick at which the counter reaches the sampling point.
    assign samp = s_r.clk_sel ? ARB_SAMPLE_PRE : ARB_SAMPLE_BUS;

    // APB decode: the slave answers in the first access cycle.
    assign setup   = apb_req.psel & ~apb_req.penable;
    assign wr      = apb_req.psel & apb_req.penable & s_r.pready
                     & apb_req.pwrite;
    assign wr_ctrl = wr & (decode(apb_req.paddr) == 3'h0);

    // Next-state logic for counter, flags, registers and pins.
    always_comb begin
        s_nxt = s_r;
        lost_ev = 1'b0;
        done_ev = 1'b0;
        ovfl_ev = 1'b0;

        s_nxt.rx_meta  = receive_line;
        s_nxt.rx_sync  = s_r.rx_meta;
        s_nxt.rx_prev  = s_r.rx_sync;
        s_nxt.osc_meta = oscillator_clock;
        s_nxt.osc_sync = s_r.osc_meta;
        s_nxt.osc_prev = s_r.osc_sync;
        s_nxt.tx_prev  = serial_tx_internal;

        s_nxt.bus_div = bus_tick ? 8'h00 : s_r.bus_div + 8'h01;
        if (src_tick) begin
            s_nxt.pre_div = pre_tick ? 8'h00 : s_r.pre_div + 8'h01;
        end
        if (pre_tick) begin
            s_nxt.half = ~s_r.half;
        end

        // Free counting while running; a wrap raises overflow.
        if (s_r.running && cnt_tick) begin
            s_nxt.count = s_r.count + 9'h001;
            if (s_r.count == COUNT_MAX) begin
                ovfl_ev = 1'b1;
            end
        end

        // Control write clears the counter and the finish flags first.
        if (wr_ctrl) begin
            s_nxt.mode    = apb_req.pwdata[CTRL_MODE_HI:CTRL_MODE_LO];
            s_nxt.clk_sel = apb_req.pwdata[CTRL_CLK_SEL];
            s_nxt.count   = 9'h000;
            s_nxt.running = 1'b0;
            s_nxt.done    = 1'b0;
            s_nxt.ovfl    = 1'b0;
            if (!apb_req.pwdata[CTRL_MODE_HI]) begin
                s_nxt.lost = 1'b0;
            end
        end

        // Mode behaviour follows the mode held before any write.
        case (s_r.mode)
            MODE_MEASURE: begin
                if (!s_r.clk_sel) begin
                    if (!s_r.running && !s_r.done && rx_fall) begin
                        s_nxt.running = 1'b1;
                        s_nxt.count   = 9'h000;
                    end else if (s_r.running && rx_fall) begin
                        s_nxt.running = 1'b0;
                        done_ev       = 1'b1;
                    end
                end else begin
                    // A line already low starts at once.
                    if (!s_r.running && !s_r.done && !s_r.rx_sync) begin
                        s_nxt.running = 1'b1;
                        s_nxt.count   = 9'h000;
                    end else if (s_r.running && rx_rise) begin
                        s_nxt.running = 1'b0;
                        done_ev       = 1'b1;
                    end
                end
            end
            MODE_ARB: begin
                if (tx_rise) begin
                    s_nxt.running  = 1'b1;
                    s_nxt.count    = 9'h000;
                    s_nxt.low_seen = 1'b0;
                end else if (s_r.running) begin
                    if (!s_r.rx_sync) begin
                        s_nxt.low_seen = 1'b1;
                    end
                    if (tx_fall && !s_r.low_seen && s_r.rx_sync) begin
                        // Wait for the next transmit rising edge.
                        s_nxt.running = 1'b0;
                        s_nxt.count   = 9'h000;
                    end
                    if (cnt_tick && s_r.count == samp - 9'h001
                        && !s_r.rx_sync) begin
                        lost_ev = 1'b1;
                    end
                end
            end
            default: begin
                // Idle and the reserved code keep the counter cleared.
                s_nxt.running = 1'b0;
                s_nxt.count   = 9'h000;
            end
        endcase

        // Hardware sets win over software clears in the same cycle.
        if (lost_ev) begin
            s_nxt.lost = 1'b1;
        end
        if (done_ev) begin
            s_nxt.done = 1'b1;
        end
        if (ovfl_ev) begin
            s_nxt.ovfl = 1'b1;
        end

        // Other registers; status bits clear on writing one.
        if (wr) begin
            case (decode(apb_req.paddr))
                3'h2: s_nxt.irq_st = s_r.irq_st & ~apb_req.pwdata[2:0];
                3'h3: s_nxt.irq_mask = apb_req.pwdata[2:0];
                3'h4: s_nxt.baud_src = apb_req.pwdata[CFG_BAUD_SRC];
                default: s_nxt.irq_mask = s_r.irq_mask;
            endcase
        end
        s_nxt.irq_st[IRQ_LOST] = s_nxt.irq_st[IRQ_LOST] | lost_ev;
        s_nxt.irq_st[IRQ_DONE] = s_nxt.irq_st[IRQ_DONE] | done_ev;
        s_nxt.irq_st[IRQ_OVFL] = s_nxt.irq_st[IRQ_OVFL] | ovfl_ev;
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);

        // Losing arbitration holds the pin recessive.
        s_nxt.tx_pin = s_nxt.lost | serial_tx_internal;

        // Read data is captured in setup, answered in the next cycle.
        s_nxt.pready  = setup;
        s_nxt.pslverr = setup & (decode(apb_req.paddr) == 3'h7);
        s_nxt.prdata  = setup ? rd_mux(s_r, decode(apb_req.paddr))
                              : 32'h0000_0000;
    end

    // The whole state is one register; reset loads constants only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign apb_rsp.prdata  = s_r.prdata;
    assign apb_rsp.pready  = s_r.pready;
    assign apb_rsp.pslverr = s_r.pslverr;
    assign transmit_pin    = s_r.tx_pin;
    assign irq             = s_r.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Checks on the counter, flags, pin and bus answer.
    a_idle_counter: assert property (
        s_r.mode == MODE_IDLE |=> s_r.count == 9'h000 && !s_r.running
    ) else $error("idle mode did not hold counter cleared");

    a_lost_forces_pin: assert property (
        s_r.lost |-> transmit_pin
    ) else $error("transmit pin not forced high while lost");

    a_ctrl_write_clear: assert property (
        wr_ctrl |=> s_r.count == 9'h000
    ) else $error("control write did not clear counter");

    a_lost_clear_path: assert property (
        wr_ctrl && !apb_req.pwdata[CTRL_MODE_HI] && s_r.mode != MODE_ARB
        |=> !s_r.lost
    ) else $error("lost flag not cleared by mode write");

    a_arb_sample_low: assert property (
        s_r.mode == MODE_ARB && s_r.running && !tx_rise && cnt_tick
        && s_r.count == samp - 9'h001 && !s_r.rx_sync
        |=> s_r.lost ##0 transmit_pin
    ) else $error("low sample did not set lost");

    a_measure_finish: assert property (
        s_r.mode == MODE_MEASURE && !s_r.clk_sel && s_r.running
        && rx_fall |=> s_r.done && !s_r.running
    ) else $error("second falling edge did not finish");

    a_overflow_set: assert property (
        s_r.running && cnt_tick && s_r.count == COUNT_MAX
        |=> s_r.ovfl ##0 s_r.irq_st[IRQ_OVFL]
    ) else $error("counter wrap did not set overflow");

    a_irq_level: assert property (
        ##1 irq == $past(|(s_nxt.irq_st & s_nxt.irq_mask))
    ) else $error("interrupt level mismatch");

    a_apb_answer: assert property (
        setup |=> apb_rsp.pready ##1 !apb_rsp.pready
    ) else $error("APB answer not one cycle after setup");

    // Measurement on the prescaler clock: start while low, stop on a rise.
    a_break_start: assert property (
        s_r.mode == MODE_MEASURE && s_r.clk_sel && !s_r.running
        && !s_r.done && !s_r.rx_sync && !wr_ctrl |=> s_r.running
    ) else $error("low line did not start break count");

    a_break_stop: assert property (
        s_r.mode == MODE_MEASURE && s_r.clk_sel && s_r.running && rx_rise
        |=> s_r.done && !s_r.running
    ) else $error("rising edge did not end break count");

    // A finished measurement must not restart until software clears it.
    a_done_blocks: assert property (
        s_r.mode == MODE_MEASURE && s_r.done && !s_r.running
        |=> !s_r.running
    ) else $error("measurement restarted while finished");

    a_flags_cleared: assert property (
        wr_ctrl && !done_ev && !ovfl_ev |=> !s_r.done && !s_r.ovfl
    ) else $error("control write left a finish flag set");

    // The counter may only step on a tick of the selected clock.
    a_bus_rate: assert property (
        s_r.mode == MODE_MEASURE && !s_r.clk_sel && s_r.running
        && !cnt_tick && !wr_ctrl |=> s_r.count == $past(s_r.count)
    ) else $error("counter stepped without a bus tick");

    a_pre_rate: assert property (
        s_r.mode == MODE_MEASURE && s_r.clk_sel && s_r.running
        && !pre_tick && !wr_ctrl |=> s_r.count == $past(s_r.count)
    ) else $error("counter stepped without a prescaler tick");

    a_reserved_idle: assert property (
        s_r.mode == 2'h3 |=> s_r.count == 9'h000 && !s_r.running
    ) else $error("reserved mode let the counter run");

    // Arbitration start, early restart and the sticky lost flag.
    a_arb_start: assert property (
        s_r.mode == MODE_ARB && tx_rise
        |=> s_r.running && s_r.count == 9'h000
    ) else $error("transmit rise did not start counter");

    a_arb_restart: assert property (
        s_r.mode == MODE_ARB && s_r.running && tx_fall && !s_r.low_seen
        && s_r.rx_sync |=> !s_r.running && s_r.count == 9'h000
    ) else $error("early transmit low did not reset counter");

    a_lost_sticky: assert property (
        s_r.lost && !wr_ctrl |=> s_r.lost
    ) else $error("lost flag cleared without a write");

    a_lost_needs_low: assert property (
        $rose(s_r.lost) |-> !$past(s_r.rx_sync)
    ) else $error("lost flag set with receive line high");

    // Read path of the top counter bit and the interrupt level.
    a_msb_read: assert property (
        setup && decode(apb_req.paddr) == 3'h0
        |=> apb_rsp.prdata[CTRL_MSB] == $past(s_r.count[8])
    ) else $error("counter top bit not read back");

    a_irq_masked: assert property (
        irq |-> |(s_r.irq_st & s_r.irq_mask)
    ) else $error("interrupt high with no unmasked status");

    c_arb_win: cover property (
        s_r.mode == MODE_ARB && s_r.running && cnt_tick
        && s_r.count == samp - 9'h001 && s_r.rx_sync
    );
    c_arb_lost: cover property (lost_ev);
    c_measure_done: cover property (done_ev && s_r.clk_sel);
    c_overflow: cover property (ovfl_ev);
    c_arb_restart: cover property (
        s_r.mode == MODE_ARB && s_r.running && tx_fall && !s_r.low_seen
    );

endmodule

// ### hw/arb_timer_pkg.sv
/*
 * Constants, register map and carrier types of the serial bus arbiter
 * and bit timer. Assumes an APB master with 32-bit data and byte
 * addresses; registers take one aligned word each.
 */
package arb_timer_pkg;

    localparam int ADDR_W = 12;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL  = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_IRQST = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_IRQMK = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_CFG   = 12'h010;

    // Control and configuration register bit positions.
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_LOST    = 5;
    localparam int CTRL_CLK_SEL = 4;
    localparam int CTRL_DONE    = 3;
    localparam int CTRL_RUNNING = 2;
    localparam int CTRL_OVFL    = 1;
    localparam int CTRL_MSB     = 0;
    localparam int CFG_BAUD_SRC = 0;

    // Interrupt status and mask bit positions.
    localparam int IRQ_LOST = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_OVFL = 2;

    // Mode encodings.
    localparam logic [1:0] MODE_IDLE    = 2'h0;
    localparam logic [1:0] MODE_MEASURE = 2'h1;
    localparam logic [1:0] MODE_ARB     = 2'h2;

    // Arbitration sampling points and counter limit.
    localparam logic [8:0] ARB_SAMPLE_BUS = 9'h038;
    localparam logic [8:0] ARB_SAMPLE_PRE = 9'h008;
    localparam logic [8:0] COUNT_MAX      = 9'h1ff;

    // Default dividers.
    localparam logic [7:0] BUS_DIV_DEF = 8'h04;
    localparam logic [7:0] PRE_DIV_DEF = 8'h01;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [31:0]       pwdata;
    } apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_type;

    typedef struct packed {
        logic       rx_meta;
        logic       rx_sync;
        logic       rx_prev;
        logic       osc_meta;
        logic       osc_sync;
        logic       osc_prev;
        logic       tx_prev;
        logic [1:0] mode;
        logic       clk_sel;
        logic       baud_src;
        logic       lost;
        logic       done;
        logic       running;
        logic       ovfl;
        logic       low_seen;
        logic [8:0] count;
        logic [7:0] bus_div;
        logic [7:0] pre_div;
        logic       half;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic [31:0] prdata;
        logic       pready;
        logic       pslverr;
        logic       tx_pin;
        logic       irq;
    } state_type;

    localparam state_type STATE_RESET = '0;

endpackage

// ### verification/serial_node_model.sv
/*
 * Model of the other nodes on the shared serial bus.
 * Assumes a wired-and bus with a pull-up, so a released bus reads high.
 */
`timescale 1ns/100ps
module serial_node_model (
    input  wire logic pclk,
    output      logic receive_line
);
    logic dominant;

    // A node driving dominant pulls the line low; the pull-up wins otherwise.
    assign receive_line = ~dominant;

    initial dominant = 1'b0;

    // Pulls the bus low or releases it, changed just after a clock edge.
    task automatic hold_low(input logic on);
        @(posedge pclk);
        dominant <= on;
    endtask
endmodule

// ### verification/tb.sv
/*
 * Self-checking bench for the arbiter and bit timer: registers over APB,
 * bit time and break measurement, arbitration and the interrupt.
 * Assumes the design package and the serial node model compile first.
 */
`timescale 1ns/100ps
module tb;
    import arb_timer_pkg::*;
    logic        pclk;
    logic        presetn;
    apb_req_type apb_req;
    apb_rsp_type apb_rsp;
    logic        receive_line;
    logic        oscillator_clock;
    logic        serial_tx_internal;
    logic        transmit_pin;
    logic        irq;
    int          num_errors;
    int          comparisons;
    logic [31:0] rd;
    logic        err;

    arb_timer dut_u (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .receive_line(receive_line),
        .oscillator_clock(oscillator_clock),
        .serial_tx_internal(serial_tx_internal),
        .transmit_pin(transmit_pin), .irq(irq));

    serial_node_model node_u (.pclk(pclk), .receive_line(receive_line));

    // Bus clock and an unrelated slower oscillator.
    always #25 pclk = ~pclk;
    always #165 oscillator_clock = ~oscillator_clock;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic bit_check(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    // Counts depend on divider phase, so allow two ticks either way.
    task automatic near(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if ($isunknown(got) || got > exp + 2 || got + 2 < exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        if (n >= 20) begin
            num_errors++;
        end
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    task automatic test_reset();
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, OFS_COUNT, 32'h0);
        check(rd, 32'h0);
        bit_check(transmit_pin, 1'b0);
        apb(1'b0, 12'h020, 32'h0);
        bit_check(err, 1'b1);
        apb(1'b1, OFS_COUNT, 32'h55);
        apb(1'b0, OFS_COUNT, 32'h0);
        check(rd, 32'h0);
        $display("test_reset done");
    endtask

    // Idle and the reserved code must both keep the counter at zero.
    task automatic test_idle();
        for (int m = 0; m < 4; m += 3) begin
            apb(1'b1, OFS_CTRL, 32'(m << 6));
            node_u.hold_low(1'b1);
            repeat (40) @(posedge pclk);
            node_u.hold_low(1'b0);
            repeat (40) @(posedge pclk);
            apb(1'b0, OFS_CTRL, 32'h0);
            check(rd, 32'(m << 6));
            apb(1'b0, OFS_COUNT, 32'h0);
            check(rd, 32'h0);
        end
        $display("test_idle done");
    endtask

    task automatic test_measure();
        int t1;
        int t2;
        apb(1'b1, OFS_IRQMK, 32'h2);
        apb(1'b1, OFS_CTRL, 32'h40);
        node_u.hold_low(1'b1);
        t1 = int'($time);
        repeat (20) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        bit_check(rd[CTRL_RUNNING], 1'b1);
        repeat (60) @(posedge pclk);
        node_u.hold_low(1'b0);
        repeat (100) @(posedge pclk);
        node_u.hold_low(1'b1);
        t2 = int'($time);
        repeat (10) @(posedge pclk);
        node_u.hold_low(1'b0);
        repeat (10) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h48);
        apb(1'b0, OFS_COUNT, 32'h0);
        near(rd, 32'((t2 - t1) / 200));
        bit_check(irq, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h40);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h40);
        apb(1'b1, OFS_IRQST, 32'h2);
        repeat (2) @(posedge pclk);
        bit_check(irq, 1'b0);
        $display("test_measure done");
    endtask

    // Break length with the line already low when measurement starts.
    task automatic test_break(input logic src, input int tick,
                              input int cyc);
        int t1;
        int n;
        logic msb;
        apb(1'b1, OFS_CFG, {31'h0, src});
        node_u.hold_low(1'b1);
        repeat (10) @(posedge pclk);
        apb(1'b1, OFS_CTRL, 32'h50);
        t1 = int'($time);
        repeat (cyc) @(posedge pclk);
        node_u.hold_low(1'b0);
        n = (int'($time) - t1) / tick;
        repeat (30) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        bit_check(rd[CTRL_RUNNING], 1'b0);
        bit_check(rd[CTRL_OVFL], n > 511);
        msb = rd[CTRL_MSB];
        apb(1'b0, OFS_COUNT, 32'h0);
        near({23'h0, msb, rd[7:0]}, 32'(n % 512));
        $display("test_break done");
    endtask

    task automatic test_arb_lost();
        apb(1'b1, OFS_IRQMK, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h80);
        node_u.hold_low(1'b1);
        serial_tx_internal <= 1'b1;
        repeat (200) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        bit_check(rd[CTRL_LOST], 1'b0);
        repeat (40) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        bit_check(rd[CTRL_LOST], 1'b1);
        bit_check(irq, 1'b1);
        serial_tx_internal <= 1'b0;
        repeat (3) @(posedge pclk);
        bit_check(transmit_pin, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h80);
        apb(1'b0, OFS_CTRL, 32'h0);
        bit_check(rd[CTRL_LOST], 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        bit_check(rd[CTRL_LOST], 1'b0);
        bit_check(transmit_pin, 1'b0);
        apb(1'b1, OFS_IRQMK, 32'h0);
        repeat (2) @(posedge pclk);
        bit_check(irq, 1'b0);
        apb(1'b1, OFS_IRQST, 32'h1);
        apb(1'b1, OFS_IRQMK, 32'h1);
        repeat (2) @(posedge pclk);
        bit_check(irq, 1'b0);
        node_u.hold_low(1'b0);
        $display("test_arb_lost done");
    endtask

    // A recessive bit seen high must not lose; an early drop restarts.
    task automatic test_arb_win();
        apb(1'b1, OFS_CTRL, 32'h80);
        serial_tx_internal <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        bit_check(rd[CTRL_RUNNING], 1'b1);
        serial_tx_internal <= 1'b0;
        repeat (5) @(posedge pclk);
        apb(1'b0, OFS_COUNT, 32'h0);
        check(rd, 32'h0);
        serial_tx_internal <= 1'b1;
        repeat (300) @(posedge pclk);
        apb(1'b0, OFS_CTRL, 32'h0);
        bit_check(rd[CTRL_LOST], 1'b0);
        bit_check(transmit_pin, 1'b1);
        serial_tx_internal <= 1'b0;
        $display("test_arb_win done");
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence: reset for ten cycles, then each scenario in turn.
    initial begin
        pclk = 1'b0;
        oscillator_clock = 1'b0;
        presetn = 1'b0;
        apb_req = '0;
        serial_tx_internal = 1'b0;
        num_errors = 0;
        comparisons = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_idle();
        test_measure();
        test_break(1'b0, 100, 300);
        test_break(1'b1, 660, 5000);
        test_break(1'b0, 100, 1200);
        test_arb_lost();
        test_arb_win();
        test_done();
    end

    // The run needs under eight thousand cycles; allow twenty thousand.
    initial begin
        #1000000;
        num_errors++;
        $display("watchdog expired at %0t", $time);
        test_done();
    end
endmodule
